//--- rtl/orsc_defines.vh
// constants shared by the optical receiver sample/convert control block
`ifndef ORSC_DEFINES_VH
`define ORSC_DEFINES_VH
// register word indices (byte address is four times the index)
`define ORSC_IDX_CONFIG 4'h0
`define ORSC_IDX_PERIOD 4'h1
`define ORSC_IDX_WIN0   4'h2
`define ORSC_IDX_WIN3   4'h5
`define ORSC_IDX_STATUS 4'h6
`define ORSC_IDX_MASK   4'h7
`define ORSC_IDX_RES0   4'h8
`define ORSC_IDX_RES3   4'hb
`define ORSC_IDX_DIFF0  4'hc
`define ORSC_IDX_DIFF1  4'hd
// config word fields
`define ORSC_CFG_RF   2:0
`define ORSC_CFG_CF   8:3
`define ORSC_CFG_GAIN 11:9
`define ORSC_CFG_DAC  15:12
// highest legal codes
`define ORSC_RF_MAX   3'h6
`define ORSC_GAIN_MAX 3'h4
`define ORSC_DAC_MAX  4'ha
// reset values
`define ORSC_PERIOD_DEF 16'h0fa0
`define ORSC_WIN_DEF    16'h00c8
// timing: tick rate and least sample window
`define ORSC_TICK_MHZ     4
`define ORSC_SAMPLE_MIN_US 50
// conversion slots in period order
`define ORSC_SLOT_RED    2'h0
`define ORSC_SLOT_REDAMB 2'h1
`define ORSC_SLOT_IR     2'h2
`define ORSC_SLOT_IRAMB  2'h3
// bus responses
`define ORSC_RESP_OKAY   2'h0
`define ORSC_RESP_SLVERR 2'h2
`endif

//--- rtl/orsc_top.v
// optical receiver sample and convert control with axi4-lite registers
//
// Function
// - low reset pin returns control to reset
// - seven feedback resistor codes selectable
// - six feedback capacitors, any combination
// - second stage gain has five settings
// - ambient dac written by host, ten steps
// - sample red, infrared and two ambient stores
// - per-signal sample window, at least 50 us unless the quarter is shorter
// - one 22-bit converter, slots in turn
// - each conversion one quarter period, one word
// - conversion starts after its sample phase
// - four raw result streams each period
// - two ambient-subtracted results each period
// - conversion-complete output for host interrupt
// - 4 MHz tick from 8 MHz crystal halved
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "orsc_defines.vh"
module orsc_top (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        rxResetN,
  input  wire        xtalIn,
  input  wire [21:0] adcResult,
  input  wire [5:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [5:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  output reg         clkOut,
  output reg  [2:0]  feedbackRes,
  output reg  [5:0]  feedbackCap,
  output reg  [2:0]  stageGain,
  output reg  [3:0]  dacCode,
  output reg  [3:0]  sampleOn,
  output reg  [3:0]  convOn,
  output reg         adcReady,
  output reg         irq
);

  // least window in ticks, derived from time and tick rate
  localparam integer MIN_TICKS_I = `ORSC_SAMPLE_MIN_US * `ORSC_TICK_MHZ;
  localparam [15:0]  MIN_TICKS   = MIN_TICKS_I[15:0];

  reg         rstMeta;          // reset pin, first stage
  reg         rstSync;          // reset pin, synchronised
  reg         xtalMeta;         // crystal, first stage
  reg         xtalSync;         // crystal, synchronised
  reg         xtalPrev;         // crystal, previous level
  reg         tick;             // one-cycle 4 MHz enable
  reg  [21:0] adcMeta;          // converter word, first stage
  reg  [21:0] adcSync;          // converter word, synchronised
  reg  [15:0] periodReg;        // pulse_repeat_period in ticks
  reg  [15:0] winReg [0:3];     // sample window per slot
  reg  [3:0]  status;           // sticky conversion-done bits
  reg  [3:0]  mask;             // interrupt mask
  reg  [21:0] resultMem [0:3];  // raw results per slot
  reg  [21:0] redDiff;          // red minus red ambient
  reg  [21:0] irDiff;           // infrared minus infrared ambient
  reg  [13:0] qCnt;             // tick count inside a quarter
  reg  [1:0]  qIdx;             // current quarter, also conv slot
  reg  [5:0]  awAddr;           // held write address
  reg         awHeld;           // write address taken
  reg  [31:0] wData;            // held write data
  reg  [3:0]  wStrb;            // held byte enables
  reg         wHeld;            // write data taken
  reg  [31:0] rdMux;            // read data selected by araddr
  reg  [1:0]  rdErr;            // read response for araddr
  reg  [31:0] cfgNew;           // config word after byte merge
  reg  [31:0] periodNew;        // period word after byte merge
  reg  [31:0] winNew;           // addressed window after byte merge

  wire        coreRst = sys_rst | ~rstSync;
  wire [3:0]  awIdx   = awAddr[5:2];
  wire [3:0]  arIdx   = araddr[5:2];
  wire [3:0]  awWin   = awIdx - `ORSC_IDX_WIN0;
  wire [3:0]  arWin   = arIdx - `ORSC_IDX_WIN0;
  wire        doWrite = awHeld & wHeld & ~bvalid;
  wire [13:0] qLen    = periodReg[15:2];
  wire [13:0] qLast   = (qLen == 14'h0) ? 14'h0 : qLen - 14'h1;
  wire        qEnd    = tick & (qCnt >= qLast);
  wire [31:0] cfgOld  = {16'h0, dacCode, stageGain, feedbackCap,
                         feedbackRes};
  wire [3:0]  next_convOn = 4'h1 << qIdx;
  wire [3:0]  next_sampleOn;

  // merge write data into an old word under the byte enables
  function [31:0] wmerge;
    input [31:0] o;
    input [31:0] d;
    input [3:0]  s;
    integer      i;
    begin
      for (i = 0; i < 4; i = i + 1)
        wmerge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  // reset pin passes two flops before use
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= rxResetN;
      rstSync <= rstMeta;
    end
  end

  // crystal halved: clkOut toggles on each crystal rise
  always @(posedge clk)
  begin
    if (coreRst)
    begin
      xtalMeta <= 1'b0;
      xtalSync <= 1'b0;
      xtalPrev <= 1'b0;
      clkOut   <= 1'b0;
      tick     <= 1'b0;
    end
    else
    begin
      xtalMeta <= xtalIn;
      xtalSync <= xtalMeta;
      xtalPrev <= xtalSync;
      tick     <= 1'b0;
      // tick on the rising half of the divided clock
      if (xtalSync & ~xtalPrev)
      begin
        clkOut <= ~clkOut;
        tick   <= ~clkOut;
      end
    end
  end

  // converter word crosses in through two flops
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      adcMeta <= 22'h0;
      adcSync <= 22'h0;
    end
    else
    begin
      adcMeta <= adcResult;
      adcSync <= adcMeta;
    end
  end

  // quarter sequencer; a shrinking period ends the quarter at once
  always @(posedge clk)
  begin
    if (coreRst)
    begin
      qCnt <= 14'h0;
      qIdx <= `ORSC_SLOT_RED;
    end
    else if (tick)
    begin
      if (qEnd)
      begin
        qCnt <= 14'h0;
        qIdx <= qIdx + 2'h1;
      end
      else
        qCnt <= qCnt + 14'h1;
    end
  end

  // each store samples in the quarter before its own conversion
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1)
    begin : gSample
      localparam integer SQI = (k + 3) % 4;
      localparam [1:0]   SQ  = SQI[1:0];  // sampling quarter
      wire [15:0] winEff = (winReg[k] < MIN_TICKS) ? MIN_TICKS
                                                   : winReg[k];
      // window counts from the quarter start, never past it
      assign next_sampleOn[k] = (qIdx == SQ) &
                                ({2'h0, qCnt} < winEff);
    end
  endgenerate

  // phase outputs registered so they leave straight from flops
  always @(posedge clk)
  begin
    if (coreRst)
    begin
      sampleOn <= 4'h0;
      // slot red during reset, so the slot stays one-hot throughout
      convOn   <= 4'h1 << `ORSC_SLOT_RED;
      irq      <= 1'b0;
    end
    else
    begin
      sampleOn <= next_sampleOn;
      convOn   <= next_convOn;
      irq      <= |(status & mask);
    end
  end

  // byte-merged config, period and window words
  always @*
  begin
    cfgNew    = wmerge(cfgOld, wData, wStrb);
    periodNew = wmerge({16'h0, periodReg}, wData, wStrb);
    winNew    = wmerge({16'h0, winReg[awWin[1:0]]}, wData, wStrb);
  end

  // software registers, results and sticky status
  always @(posedge clk)
  begin : regFile
    integer j;
    if (coreRst)
    begin
      feedbackRes <= 3'h0;
      feedbackCap <= 6'h0;
      stageGain   <= 3'h0;
      dacCode     <= 4'h0;
      periodReg   <= `ORSC_PERIOD_DEF;
      for (j = 0; j < 4; j = j + 1)
      begin
        winReg[j]    <= `ORSC_WIN_DEF;
        resultMem[j] <= 22'h0;
      end
      status   <= 4'h0;
      mask     <= 4'h0;
      redDiff  <= 22'h0;
      irDiff   <= 22'h0;
      adcReady <= 1'b0;
    end
    else
    begin
      adcReady <= qEnd;
      // end of quarter: one result word for the converting slot
      if (qEnd)
      begin
        resultMem[qIdx] <= adcSync;
        if (qIdx == `ORSC_SLOT_REDAMB)
          redDiff <= resultMem[`ORSC_SLOT_RED] - adcSync;
        if (qIdx == `ORSC_SLOT_IRAMB)
          irDiff <= resultMem[`ORSC_SLOT_IR] - adcSync;
      end
      // set beats a write-one clear in the same cycle
      status <= (status & ~((doWrite & (awIdx == `ORSC_IDX_STATUS))
                            ? wData[3:0] & {4{wStrb[0]}} : 4'h0))
                | (qEnd ? next_convOn : 4'h0);
      if (doWrite)
      begin
        if (awIdx == `ORSC_IDX_CONFIG)
        begin
          // out-of-range codes keep the old setting
          if (cfgNew[`ORSC_CFG_RF] <= `ORSC_RF_MAX)
            feedbackRes <= cfgNew[`ORSC_CFG_RF];
          feedbackCap <= cfgNew[`ORSC_CFG_CF];
          if (cfgNew[`ORSC_CFG_GAIN] <= `ORSC_GAIN_MAX)
            stageGain <= cfgNew[`ORSC_CFG_GAIN];
          if (cfgNew[`ORSC_CFG_DAC] <= `ORSC_DAC_MAX)
            dacCode <= cfgNew[`ORSC_CFG_DAC];
        end
        if (awIdx == `ORSC_IDX_PERIOD)
          periodReg <= periodNew[15:0];
        if (awIdx >= `ORSC_IDX_WIN0 && awIdx <= `ORSC_IDX_WIN3)
          winReg[awWin[1:0]] <= winNew[15:0];
        if (awIdx == `ORSC_IDX_MASK && wStrb[0])
          mask <= wData[3:0];
      end
    end
  end

  // read data and response for the offered read address
  always @*
  begin
    rdMux = 32'h0;
    rdErr = `ORSC_RESP_OKAY;
    if (arIdx == `ORSC_IDX_CONFIG)
      rdMux = cfgOld;
    else if (arIdx == `ORSC_IDX_PERIOD)
      rdMux = {16'h0, periodReg};
    else if (arIdx >= `ORSC_IDX_WIN0 && arIdx <= `ORSC_IDX_WIN3)
      rdMux = {16'h0, winReg[arWin[1:0]]};
    else if (arIdx == `ORSC_IDX_STATUS)
      rdMux = {28'h0, status};
    else if (arIdx == `ORSC_IDX_MASK)
      rdMux = {28'h0, mask};
    else if (arIdx >= `ORSC_IDX_RES0 && arIdx <= `ORSC_IDX_RES3)
      rdMux = {10'h0, resultMem[arIdx[1:0]]};
    else if (arIdx == `ORSC_IDX_DIFF0)
      rdMux = {10'h0, redDiff};
    else if (arIdx == `ORSC_IDX_DIFF1)
      rdMux = {10'h0, irDiff};
    else
      rdErr = `ORSC_RESP_SLVERR;  // unmapped word
  end

  // axi4-lite handshakes; address and data taken in either order
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      awready <= 1'b1;
      wready  <= 1'b1;
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awAddr  <= 6'h0;
      wData   <= 32'h0;
      wStrb   <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `ORSC_RESP_OKAY;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `ORSC_RESP_OKAY;
    end
    else
    begin
      if (awvalid & awready)
      begin
        awAddr  <= awaddr;
        awHeld  <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid & wready)
      begin
        wData  <= wdata;
        wStrb  <= wstrb;
        wHeld  <= 1'b1;
        wready <= 1'b0;
      end
      // both halves held: the register file commits this cycle
      if (doWrite)
      begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= (awIdx > `ORSC_IDX_DIFF1) ? `ORSC_RESP_SLVERR
                                            : `ORSC_RESP_OKAY;
      end
      // one write at a time: readies return after the response
      if (bvalid & bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (arvalid & arready)
      begin
        rdata   <= rdMux;
        rresp   <= rdErr;
        rvalid  <= 1'b1;
        arready <= 1'b0;
      end
      if (rvalid & rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // orsc_top

//--- testbench/orsc_top_monitor.sv
// port checker for the receiver sample and convert control
`timescale 1ns/1ps
module orsc_mon (
  input wire        clk, sys_rst, adcReady,
  input wire [3:0]  sampleOn, convOn, dacCode,
  input wire [2:0]  feedbackRes, stageGain,
  input wire        awvalid, awready, wvalid, wready, bvalid, bready,
  input wire        arvalid, arready, rvalid, rready,
  input wire [1:0]  bresp,
  input wire [31:0] rdata
);
  // all checks on the bus clock, quiet while the bus is in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_conv_onehot: assert property (!$past(sys_rst) |-> $onehot(convOn))
    else $error("converter slot not one-hot");
  // 0001 also follows a receiver reset, so it is left out
  a_conv_order: assert property ($changed(convOn) && convOn != 4'h1
    |-> convOn == {$past(convOn[2:0]), 1'b0})
    else $error("converter slot order broken");
  // the result strobe comes one cycle ahead of the slot change
  a_conv_ready: assert property ($changed(convOn) && convOn != 4'h1
    |-> $past(adcReady)) else $error("no result at slot end");
  a_ready_pulse: assert property (adcReady |=> !adcReady)
    else $error("result strobe longer than one cycle");
  // a slot samples only in the quarter before its conversion
  a_samp_before: assert property (
    (sampleOn & ~{convOn[2:0], convOn[3]}) == 4'h0)
    else $error("sampling overlaps own conversion");
  a_samp_single: assert property ($onehot0(sampleOn))
    else $error("two stores sampled at once");
  a_code_range: assert property (feedbackRes <= 3'h6 && stageGain <= 3'h4
    && dacCode <= 4'ha) else $error("setting code out of range");
  a_read_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_lat: assert property (awvalid && awready && wvalid && wready
    |=> !bvalid ##1 bvalid) else $error("write answer timing");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_data_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule // orsc_mon
bind orsc_top orsc_mon mon_u (.*);

//--- testbench/orsc_conv_model.sv
// crystal and converter stand-in facing the receiver core
`timescale 1ns/1ps
module orsc_conv_model (
  input  wire [3:0]  convOn,
  output reg         xtalIn,
  output reg  [21:0] adcResult
);
  initial xtalIn = 1'b0;
  // free running 8 MHz crystal, unrelated to the bus clock
  always #62.5 xtalIn = ~xtalIn;
  // one word per slot, steady over the quarter so capture is exact
  always @*
    case (convOn)
      4'h1:    adcResult = 22'h012345;
      4'h2:    adcResult = 22'h023456;
      4'h4:    adcResult = 22'h3abcde;
      4'h8:    adcResult = 22'h001111;
      default: adcResult = 22'h2aaaaa;
    endcase
endmodule // orsc_conv_model

//--- testbench/orsc_top_bench.sv
// self-checking bench of the receiver control block
`timescale 1ns/1ps
module orsc_top_bench;
  reg         clk = 0, sys_rst = 1, rxResetN = 1;
  reg  [5:0]  awaddr = 0, araddr = 0;
  reg  [31:0] wdata = 0;
  reg  [3:0]  wstrb = 0;
  reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire        xtalIn, awready, wready, bvalid, arready, rvalid;
  wire        clkOut, adcReady, irq;
  wire [21:0] adcResult;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [2:0]  feedbackRes, stageGain;
  wire [5:0]  feedbackCap;
  wire [3:0]  dacCode, sampleOn, convOn;
  integer     fails = 0, cmp_count = 0, i;
  integer     tg = 0, t0;     // divided clock edge count
  reg         cPrev = 0;      // divided clock, last level seen
  reg  [31:0] x = 32'h8ec4, cfg, m;
  reg  [65:0] q[$], e;        // notes: mask, response, data
  // raw red, red amb, ir, ir amb, then both differences
  reg  [21:0] ev [0:5] = '{22'h012345, 22'h023456, 22'h3abcde,
                           22'h001111, 22'h3eeeef, 22'h3aabcd};
  always #4 clk = ~clk;
  orsc_top dut_u (.*);
  orsc_conv_model model_u (.*);
  // divided clock edges counted on the bus clock
  always @(posedge clk)
  begin
    tg    <= tg + (clkOut !== cPrev);
    cPrev <= clkOut;
  end
  task check(input string n, input [31:0] s, input [31:0] v);
    begin
      cmp_count = cmp_count + 1;
      if (s !== v)
      begin
        fails = fails + 1;
        $display("wrong value %s expected %h seen %h", n, v, s);
      end
    end
  endtask
  function [31:0] rnd;
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      rnd = x;
    end
  endfunction
  // address and data offered together, each dropped when taken
  task wr(input [5:0] a, input [31:0] d);
    reg ta, tw;
    begin
      ta = 0;
      tw = 0;
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= 4'hf;
      awvalid <= 1; wvalid <= 1; bready <= 1;
      while (!(ta && tw))
      begin
        @(posedge clk);
        if (awready) begin ta = 1; awvalid <= 0; end
        if (wready) begin tw = 1; wvalid <= 0; end
      end
      do @(posedge clk); while (!bvalid);
      bready <= 0;
      // words above the diff pair answer with a slave error
      check("bresp", {30'h0, bresp}, (a[5:2] > 4'hd) ? 32'h2 : 32'h0);
    end
  endtask
  task rd(input [5:0] a, input [31:0] v, input [31:0] mk, input [1:0] r);
    begin
      q.push_back({mk, r, v});
      @(posedge clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge clk); while (!arready);
      arvalid <= 0;
      do @(posedge clk); while (!rvalid);
      rready <= 0;
    end
  endtask
  task wait_rdy(input integer n);
    repeat (n) do @(posedge clk); while (!adcReady);
  endtask
  // read answers are compared against the oldest note
  always @(posedge clk)
    if (rvalid && rready)
    begin
      e = q.pop_front();
      check("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
      check("rdata", rdata & e[65:34], e[31:0]);
    end
  task complete_run;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // run needs about 38k cycles at most
  initial
  begin
    repeat (90000) @(posedge clk);
    fails = fails + 1;
    complete_run;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    rd(6'h04, 32'h0fa0, '1, 2'h0);
    rd(6'h00, 32'h0, '1, 2'h0);
    for (i = 2; i < 6; i = i + 1) rd(4 * i, 32'h00c8, '1, 2'h0);
    rd(6'h1c, 32'h0, '1, 2'h0);
    rd(6'h38, 32'h0, '1, 2'h2);
    wr(6'h3c, 32'h0);
    // short period: a quarter equals the least window
    wr(6'h04, 32'd800);
    for (i = 2; i < 6; i = i + 1) wr(4 * i, 32'd200);
    wr(6'h1c, 32'h1);
    // 8 us holds 64 half periods of the 4 MHz output
    t0 = tg;
    repeat (1000) @(posedge clk);
    t0 = tg - t0;
    check("clkOut", {31'h0, t0 >= 63 && t0 <= 65}, 32'h1);
    for (i = 0; i < 4; i = i + 1)
    begin
      m = rnd();
      cfg = {16'h0, 4'(m % 11), 3'(m[15:8] % 5), m[21:16], 3'(m[31:24] % 7)};
      wr(6'h00, cfg);
      @(posedge clk);
      check("settings", {16'h0, dacCode, stageGain, feedbackCap, feedbackRes}, cfg);
    end
    // illegal resistor code must leave the resistor field alone
    wr(6'h00, cfg | 32'h7);
    @(posedge clk);
    check("settings", {16'h0, dacCode, stageGain, feedbackCap, feedbackRes}, cfg);
    wait_rdy(5);
    for (i = 0; i < 6; i = i + 1) rd(32 + 4 * i, ev[i], 32'h3fffff, 2'h0);
    check("irq", {31'h0, irq}, 32'h1);
    wr(6'h18, 32'hf);
    repeat (2) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h0);
    wr(6'h1c, 32'h0);
    wait_rdy(1);
    repeat (2) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h0);
    rxResetN <= 0;
    repeat (4) @(posedge clk);
    rxResetN <= 1;
    repeat (4) @(posedge clk);
    check("settings", {dacCode, stageGain, feedbackCap, feedbackRes}, 32'h0);
    rd(6'h04, 32'h0fa0, '1, 2'h0);
    complete_run;
  end
endmodule // orsc_top_bench
